//--- mts_sequencer.sv
// Measurement trigger sequencer: idle, setup, wait-for-trigger, delay, sample.
// Assumes commands are one-cycle pulses on sys_clk; ext_trig is asynchronous.
//
// Overview of operation
// - Store-mode acquire enters wait-for-trigger
// - Store-mode readings kept in 512-entry memory
// - Store select: keep readings or discard
// - Direct-read sends readings to output buffer
// - Trigger source bus, immediate, external; readable
// - Programmable delay before every sample
// - Auto delay from function, range, aperture, filter
// - Explicit delay clears auto; auto readable
// - Samples per trigger 1 to 50000
// - Trigger count 1 to 50000 then idle; trigger_count is not clamped here, 0 acts as 1 and up to 131071 run
// - Unbounded triggers until device clear
// - Local control ignores trigger count
// - Fetch copies stored readings to output
// - Points query returns stored reading count
// - 20 ms setup ignores external triggers
// - Fetch with storage off raises error
// - Triggers accepted only in wait-for-trigger
`timescale 1ns/1ps
`include "mts_regs.svh"
module mts_sequencer #(
	parameter int SETUP_CYC = `MTS_SETUP_CYC,
	parameter int CYC_PER_US = `MTS_CLK_HZ / 1000000
) (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Commands, one-cycle pulses
	input wire logic store_mode_acquire_cmd,
	input wire logic direct_read_cmd,
	input wire logic fetch_cmd,
	input wire logic bus_trigger_cmd,
	input wire logic device_clear,
	input wire logic delay_write,
	input wire logic auto_delay_write,
	// Configuration
	input wire logic [1:0] trig_source_sel,
	input wire logic trig_source_write,
	input wire logic [31:0] delay_us,
	input wire logic auto_delay_in,
	input wire logic [31:0] auto_delay_us,
	input wire logic [16:0] sample_count,
	input wire logic [16:0] trigger_count,
	input wire logic trigger_infinite,
	input wire logic store_enable,
	input wire logic local_mode,
	// External trigger pin
	input wire logic ext_trig,
	// Measurement engine
	output logic meas_start,
	input wire logic meas_done,
	input wire logic [23:0] meas_result,
	// Output buffer
	output logic out_valid,
	input wire logic out_ready,
	output logic [23:0] out_data,
	// Status
	output logic [1:0] trig_source,
	output logic auto_delay_on,
	output logic [9:0] stored_reading_count_query,
	output logic waiting_for_trigger,
	output logic idle,
	output logic fetch_error
);
	typedef struct packed {
		mts_pkg::mts_state_t state;
		logic direct;
		logic [1:0] src;
		logic auto;
		logic [31:0] cnt;
		logic [7:0] pre;
		logic [16:0] samp_left;
		logic [16:0] trig_done;
		logic busy;
		logic [8:0] wr_ptr;
		logic [9:0] points;
		logic [9:0] rd_idx;
		logic err;
		logic start;
		logic hold;
		logic [23:0] rdg;
		logic is_idle;
		logic is_wait;
		logic [511:0][23:0] mem;
	} mts_seq_t;
	mts_seq_t st_reg;
	mts_seq_t st_next;
	logic ext_rise;
	logic buf_in_valid;
	logic buf_in_ready;
	logic [23:0] buf_in_data;
	logic trig_hit;
	logic [31:0] delay_val_us;
	logic last_trig;
	mts_sync u_ext_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.d(ext_trig),
		.rise(ext_rise)
	);
	mts_buf2 u_out_buf (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(buf_in_data),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_data)
	);
	always_comb begin
		st_next = st_reg;
		st_next.start = 1'b0;
		buf_in_valid = 1'b0;
		buf_in_data = meas_result;
		// Trigger sources; external edges only count in wait state
		unique case (st_reg.src)
			`MTS_SRC_BUS: trig_hit = bus_trigger_cmd;
			`MTS_SRC_EXT: trig_hit = ext_rise;
			default: trig_hit = 1'b1;
		endcase
		// Auto delay is supplied by the range logic that knows the setup
		delay_val_us = st_reg.auto ? auto_delay_us : delay_us;
		// Local control ignores the trigger count
		last_trig = !trigger_infinite && !local_mode &&
			(17'(st_reg.trig_done + 17'h00001) >= trigger_count);
		if (trig_source_write) begin
			st_next.src = trig_source_sel;
		end
		if (delay_write) begin
			st_next.auto = 1'b0;
		end else if (auto_delay_write) begin
			st_next.auto = auto_delay_in;
		end
		unique case (st_reg.state)
			mts_pkg::MTS_IDLE: begin
				if (store_mode_acquire_cmd || direct_read_cmd) begin
					st_next.state = mts_pkg::MTS_SETUP;
					st_next.direct = direct_read_cmd;
					st_next.cnt = '0;
					st_next.trig_done = '0;
					st_next.err = 1'b0;
					// Acquire empties memory even with storage off
					if (store_mode_acquire_cmd) begin
						st_next.wr_ptr = '0;
						st_next.points = '0;
					end
				end else if (fetch_cmd) begin
					if (!store_enable) begin
						st_next.err = 1'b1;
					end else begin
						st_next.err = 1'b0;
						st_next.rd_idx = '0;
						st_next.state = mts_pkg::MTS_FETCH;
					end
				end
			end
			mts_pkg::MTS_SETUP: begin
				// Setup time lets external triggers settle; edges here are dropped
				if (st_reg.cnt >= 32'(SETUP_CYC - 1)) begin
					st_next.state = mts_pkg::MTS_WAIT;
				end else begin
					st_next.cnt = st_reg.cnt + 32'h00000001;
				end
			end
			mts_pkg::MTS_WAIT: begin
				if (trig_hit) begin
					st_next.state = mts_pkg::MTS_DELAY;
					st_next.samp_left = (sample_count < `MTS_CNT_MIN) ? `MTS_CNT_MIN :
						(sample_count > `MTS_CNT_MAX) ? `MTS_CNT_MAX : sample_count;
					st_next.cnt = '0;
					st_next.pre = '0;
				end
			end
			mts_pkg::MTS_DELAY: begin
				// Microsecond prescaler keeps 3600 s inside a 32-bit count
				if (st_reg.cnt >= delay_val_us) begin
					st_next.state = mts_pkg::MTS_SAMPLE;
					st_next.start = 1'b1;
					st_next.busy = 1'b1;
				end else if (st_reg.pre >= 8'(CYC_PER_US - 1)) begin
					st_next.pre = '0;
					st_next.cnt = st_reg.cnt + 32'h00000001;
				end else begin
					st_next.pre = st_reg.pre + 8'h01;
				end
			end
			mts_pkg::MTS_SAMPLE: begin
				// Direct reading waits in hold until the buffer takes it
				buf_in_data = st_reg.rdg;
				buf_in_valid = st_reg.hold;
				if (st_reg.hold && buf_in_ready) begin
					st_next.hold = 1'b0;
				end
				if (st_reg.busy && meas_done) begin
					st_next.busy = 1'b0;
					if (st_reg.direct) begin
						st_next.rdg = meas_result;
						st_next.hold = 1'b1;
					end else if (store_enable && st_reg.points < 10'(`MTS_MEM_DEPTH)) begin
						st_next.mem[st_reg.wr_ptr] = meas_result;
						st_next.wr_ptr = st_reg.wr_ptr + 9'h001;
						st_next.points = st_reg.points + 10'h001;
					end
				end
				// One extra cycle per sample, but a stalled reader loses nothing
				if (!st_reg.busy && !st_reg.hold) begin
					if (st_reg.samp_left > 17'h00001) begin
						st_next.samp_left = st_reg.samp_left - 17'h00001;
						st_next.cnt = '0;
						st_next.pre = '0;
						st_next.state = mts_pkg::MTS_DELAY;
					end else if (last_trig) begin
						st_next.state = mts_pkg::MTS_IDLE;
					end else begin
						st_next.trig_done = st_reg.trig_done + 17'h00001;
						st_next.state = mts_pkg::MTS_WAIT;
					end
				end
			end
			mts_pkg::MTS_FETCH: begin
				buf_in_data = st_reg.mem[st_reg.rd_idx[8:0]];
				if (st_reg.rd_idx >= st_reg.points) begin
					st_next.state = mts_pkg::MTS_IDLE;
				end else begin
					buf_in_valid = 1'b1;
					if (buf_in_ready) begin
						st_next.rd_idx = st_reg.rd_idx + 10'h001;
					end
				end
			end
			default: st_next.state = mts_pkg::MTS_IDLE;
		endcase
		if (device_clear) begin
			st_next.state = mts_pkg::MTS_IDLE;
			st_next.busy = 1'b0;
			st_next.hold = 1'b0;
		end
		// State flags registered so status outputs come from flops
		st_next.is_idle = (st_next.state == mts_pkg::MTS_IDLE);
		st_next.is_wait = (st_next.state == mts_pkg::MTS_WAIT);
		if (!clk_en) begin
			st_next = st_reg;
		end
	end
	// Memory is large but flops keep the design single-style
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.src <= `MTS_SRC_RESET;
			st_reg.auto <= 1'b1;
			st_reg.is_idle <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end
	assign meas_start = st_reg.start;
	assign trig_source = st_reg.src;
	assign auto_delay_on = st_reg.auto;
	assign stored_reading_count_query = st_reg.points;
	assign waiting_for_trigger = st_reg.is_wait;
	assign idle = st_reg.is_idle;
	assign fetch_error = st_reg.err;
endmodule // mts_sequencer

//--- mts_regs.svh
// Timing counts, widths and reset values for the trigger sequencer.
// Assumes a 200 MHz system clock.
`ifndef MTS_REGS_SVH
`define MTS_REGS_SVH
`define MTS_CLK_HZ 200000000
`define MTS_SETUP_MS 20
`define MTS_SETUP_CYC ((`MTS_SETUP_MS * `MTS_CLK_HZ) / 1000)
`define MTS_MEM_DEPTH 512
`define MTS_CNT_MAX 17'h0C350
`define MTS_CNT_MIN 17'h00001
`define MTS_DELAY_MAX_S 12'hE10
`define MTS_RESULT_W 24
`define MTS_SRC_BUS 2'h0
`define MTS_SRC_IMM 2'h1
`define MTS_SRC_EXT 2'h2
`define MTS_SRC_RESET 2'h1
`endif

//--- mts_pkg.sv
// Types shared by the trigger sequencer modules.
// Assumes mts_regs.svh is compiled alongside.
package mts_pkg;
	typedef enum logic [2:0] {
		MTS_IDLE = 3'b000,
		MTS_SETUP = 3'b001,
		MTS_WAIT = 3'b010,
		MTS_DELAY = 3'b011,
		MTS_SAMPLE = 3'b100,
		MTS_FETCH = 3'b101
	} mts_state_t;
endpackage

//--- mts_sync.sv
// Two-flop synchroniser with a rising edge pulse behind it.
// Assumes d comes from outside the sys_clk domain.
`timescale 1ns/1ps
module mts_sync (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Data
	input wire logic d,
	output logic rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} mts_sync_t;
	mts_sync_t st_reg;
	mts_sync_t st_next;
	always_comb begin
		st_next = st_reg;
		if (clk_en) begin
			st_next.s1 = d;
			st_next.s2 = st_reg.s1;
			st_next.s3 = st_reg.s2;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	// One pulse per edge, a held level never retriggers
	assign rise = st_reg.s2 & ~st_reg.s3;
endmodule // mts_sync

//--- mts_buf2.sv
// Two-entry skid buffer with valid and ready on both sides.
// Assumes a single clock; out_ready may stall at will.
`timescale 1ns/1ps
module mts_buf2 (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [23:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [23:0] out_data
);
	typedef struct packed {
		logic [1:0][23:0] mem;
		logic rd;
		logic wr;
		logic [1:0] cnt;
		logic vld;
		logic [23:0] head;
	} mts_buf_t;
	mts_buf_t st_reg;
	mts_buf_t st_next;
	logic push;
	logic pop;
	always_comb begin
		st_next = st_reg;
		push = in_valid && (st_reg.cnt != 2'h2);
		pop = (st_reg.cnt != 2'h0) && out_ready;
		if (clk_en) begin
			if (push) begin
				st_next.mem[st_reg.wr] = in_data;
				st_next.wr = ~st_reg.wr;
			end
			if (pop) begin
				st_next.rd = ~st_reg.rd;
			end
			st_next.cnt = 2'(st_reg.cnt + {1'b0, push} - {1'b0, pop});
		end
		// Registered copies so the drain side comes straight from flops
		st_next.vld = (st_next.cnt != 2'h0);
		st_next.head = st_next.mem[st_next.rd];
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	// Registered state drives every output
	assign in_ready = (st_reg.cnt != 2'h2);
	assign out_valid = st_reg.vld;
	assign out_data = st_reg.head;
endmodule // mts_buf2

//--- mts_seq_properties.sv
// Port checks for the trigger sequencer.
// Assumes one-cycle command pulses; bound onto mts_sequencer below.
`timescale 1ns/1ps
module mts_seq_properties #(
	parameter int SETUP_CYC = 10
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Commands
	input wire logic store_mode_acquire_cmd,
	input wire logic fetch_cmd,
	input wire logic bus_trigger_cmd,
	input wire logic device_clear,
	input wire logic delay_write,
	input wire logic store_enable,
	// Outputs
	input wire logic meas_start,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [23:0] out_data,
	input wire logic auto_delay_on,
	input wire logic [9:0] stored_reading_count_query,
	input wire logic waiting_for_trigger,
	input wire logic idle,
	input wire logic fetch_error
);
	localparam int SLO = SETUP_CYC;
	localparam int SHI = SETUP_CYC + 2;
	logic go;
	assign go = idle && clk_en && store_mode_acquire_cmd;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_SETUP_QUIET: assert property (go |=> !waiting_for_trigger [*8])
		else $error("waiting inside setup");
	AST_SETUP_WAIT: assert property (go |-> ##[SLO:SHI] waiting_for_trigger)
		else $error("no wait after setup");
	AST_ACQ_CLEARS: assert property (go |=> stored_reading_count_query == 10'h000)
		else $error("points not cleared");
	AST_POINTS_MAX: assert property (stored_reading_count_query <= 10'h200)
		else $error("points above depth");
	AST_IDLE_TRIG: assert property (idle && bus_trigger_cmd && !go |=> idle && !meas_start)
		else $error("trigger taken in idle");
	AST_START_PULSE: assert property (meas_start |=> !meas_start)
		else $error("start too long");
	AST_AUTO_OFF: assert property (idle && clk_en && delay_write |=> !auto_delay_on)
		else $error("auto delay kept");
	AST_FETCH_ERR: assert property (idle && clk_en && fetch_cmd && !store_enable |=> fetch_error)
		else $error("no fetch error");
	AST_CLEAR: assert property (clk_en && device_clear |=> idle)
		else $error("clear missed");
	AST_OUT_HOLD: assert property (out_valid && !out_ready && !device_clear |=> out_valid && $stable(out_data))
		else $error("word lost in stall");
	cover property (go);
	cover property (out_valid && !out_ready);
	cover property (fetch_error);
endmodule // mts_seq_properties
bind mts_sequencer mts_seq_properties #(.SETUP_CYC(SETUP_CYC)) u_props (
	.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .fetch_cmd(fetch_cmd),
	.store_mode_acquire_cmd(store_mode_acquire_cmd), .bus_trigger_cmd(bus_trigger_cmd),
	.device_clear(device_clear), .delay_write(delay_write), .store_enable(store_enable),
	.meas_start(meas_start), .out_valid(out_valid), .out_ready(out_ready),
	.out_data(out_data), .auto_delay_on(auto_delay_on), .idle(idle),
	.stored_reading_count_query(stored_reading_count_query),
	.waiting_for_trigger(waiting_for_trigger), .fetch_error(fetch_error));

//--- mts_engine_model.sv
// Engine and output reader beyond the sequencer.
// Assumes meas_start is a one-cycle pulse.
`timescale 1ns/1ps
module mts_engine_model #(
	parameter logic [23:0] BASE = 24'h0A0100
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Engine
	input wire logic meas_start,
	output logic meas_done,
	output logic [23:0] meas_result,
	// Reader
	input wire logic slow,
	output logic out_ready
);
	logic [23:0] seq;
	logic [2:0] cnt;
	logic busy;
	always @(negedge sys_clk or posedge rst) begin
		if (rst) begin
			{meas_done, busy, cnt, out_ready} <= '0;
			seq <= BASE;
			meas_result <= ~BASE;
		end else begin
			meas_done <= 1'h0;
			// Result not held outside the done pulse
			meas_result <= ~meas_result;
			out_ready <= !slow || !out_ready;
			if (meas_start) begin
				busy <= 1'h1;
				cnt <= 3'h3;
			end else if (busy && cnt == 3'h0) begin
				busy <= 1'h0;
				meas_done <= 1'h1;
				meas_result <= seq;
				seq <= seq + 24'h000001;
			end else if (busy) begin
				cnt <= cnt - 3'h1;
			end
		end
	end
endmodule // mts_engine_model

//--- tb_measurement_trigger_sequencer.sv
// Self-checking bench for the trigger sequencer.
// Assumes mts_engine_model stands at the engine and reader side.
`timescale 1ns/1ps
`include "mts_regs.svh"
module tb_measurement_trigger_sequencer;
	localparam logic [23:0] BASE = 24'h0A0100;
	logic sys_clk, rst, acq, drd, fch, btrig, dclr, dwr, awr, tsw, ain, sten, lcl, inf, ext, slow;
	logic [1:0] tsel, tsrc;
	logic [31:0] dly, adly;
	logic [16:0] scnt, tcnt;
	logic mst, mdn, ov, ordy, aon, wft, idl, ferr;
	logic [23:0] mres, od;
	logic [9:0] pts;
	int mismatches, checked, cyc, nd;
	mts_sequencer #(.SETUP_CYC(10)) DUT (.sys_clk(sys_clk), .rst(rst), .clk_en(1'h1),
		.store_mode_acquire_cmd(acq), .direct_read_cmd(drd), .fetch_cmd(fch),
		.bus_trigger_cmd(btrig), .device_clear(dclr), .delay_write(dwr),
		.auto_delay_write(awr), .trig_source_sel(tsel), .trig_source_write(tsw),
		.delay_us(dly), .auto_delay_in(ain), .auto_delay_us(adly), .sample_count(scnt),
		.trigger_count(tcnt), .trigger_infinite(inf), .store_enable(sten), .local_mode(lcl),
		.ext_trig(ext), .meas_start(mst), .meas_done(mdn), .meas_result(mres),
		.out_valid(ov), .out_ready(ordy), .out_data(od), .trig_source(tsrc),
		.auto_delay_on(aon), .stored_reading_count_query(pts), .waiting_for_trigger(wft),
		.idle(idl), .fetch_error(ferr));
	mts_engine_model #(.BASE(BASE)) u_eng (.sys_clk(sys_clk), .rst(rst), .meas_start(mst),
		.meas_done(mdn), .meas_result(mres), .slow(slow), .out_ready(ordy));
	initial begin
		sys_clk = 1'h0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (mdn === 1'h1)
			nd++;
		if (cyc > 40000) begin
			mismatches++;
			results();
		end
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge sys_clk) s = 1'h1;
		@(negedge sys_clk) s = 1'h0;
	endtask
	// Bounded poll: idle when w, else waiting
	task automatic wt(bit w, int lim);
		for (int i = 0; i < lim && (w ? idl : wft) !== 1'h1; i++)
			@(negedge sys_clk);
		chk(w ? "idle" : "waiting", 1, w ? idl : wft);
	endtask
	task automatic src(logic [1:0] v);
		tsel = v;
		pulse(tsw);
		chk("source", v, tsrc);
	endtask
	task automatic drain(int n, logic [23:0] first);
		int i = 0;
		int w = 0;
		while (i < n && w < 5000) begin
			// Reader's ready settles just after the falling edge
			@(negedge sys_clk);
			#1;
			w++;
			if (ov === 1'h1 && ordy === 1'h1) begin
				chk("word", first + i, od);
				i++;
			end
		end
		@(negedge sys_clk);
		chk("words", n, i);
	endtask
	task automatic t_store(int s, int t, int n);
		int b = nd;
		scnt = s[16:0];
		tcnt = t[16:0];
		src(2'h1);
		pulse(acq);
		wt(1'h1, 30000);
		chk("points", n, pts);
		chk("samples", s * t, nd - b);
		slow = (n > 100);
		pulse(fch);
		drain(n, BASE + b[23:0]);
		chk("empty", 0, ov);
		$display("store done");
	endtask
	task automatic t_discard();
		scnt = 17'h00001;
		tcnt = 17'h00001;
		sten = 1'h0;
		pulse(acq);
		wt(1'h1, 100);
		chk("points", 0, pts);
		pulse(fch);
		chk("fetch error", 1, ferr);
		sten = 1'h1;
		$display("discard done");
	endtask
	task automatic t_direct();
		int b = nd;
		tcnt = 17'h00002;
		src(2'h0);
		pulse(btrig);
		repeat (8) @(negedge sys_clk);
		chk("idle trigger", b, nd);
		pulse(drd);
		repeat (2) begin
			wt(1'h0, 100);
			pulse(btrig);
			drain(1, BASE + b[23:0]);
			b++;
		end
		wt(1'h1, 100);
		chk("points", 0, pts);
		$display("direct done");
	endtask
	task automatic t_ext();
		int b = nd;
		tcnt = 17'h00001;
		src(2'h2);
		pulse(acq);
		ext = 1'h1;
		wt(1'h0, 30);
		repeat (20) @(negedge sys_clk);
		chk("held level", b, nd);
		ext = 1'h0;
		repeat (4) @(negedge sys_clk);
		ext = 1'h1;
		wt(1'h1, 100);
		chk("ext edge", b + 1, nd);
		ext = 1'h0;
		$display("ext done");
	endtask
	task automatic meas(int lo);
		int n = 0;
		pulse(acq);
		wt(1'h0, 30);
		while (mst !== 1'h1 && n < 1000) begin
			@(negedge sys_clk);
			n++;
		end
		chk("delay", 1, n >= lo && n <= lo + 4);
		wt(1'h1, 100);
	endtask
	task automatic t_delay();
		src(2'h1);
		dly = 32'h00000001;
		pulse(dwr);
		chk("auto off", 0, aon);
		meas(200);
		adly = 32'h00000002;
		ain = 1'h1;
		pulse(awr);
		chk("auto on", 1, aon);
		meas(400);
		$display("delay done");
	endtask
	task automatic t_free();
		dly = 32'h00000000;
		pulse(dwr);
		for (int k = 0; k < 2; k++) begin
			inf = (k == 0);
			lcl = (k == 1);
			pulse(acq);
			repeat (300) @(negedge sys_clk);
			chk("running", 0, idl);
			pulse(dclr);
			chk("cleared", 1, idl);
		end
		inf = 1'h0;
		lcl = 1'h0;
		$display("free run done");
	endtask
	task automatic results();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		{acq, drd, fch, btrig, dclr, dwr, awr, tsw, ain, lcl, inf, ext, slow} = '0;
		sten = 1'h1;
		tsel = 2'h0;
		dly = 32'h00000000;
		adly = 32'h00000000;
		scnt = 17'h00001;
		tcnt = 17'h00001;
		rst = 1'h1;
		repeat (16) @(negedge sys_clk);
		rst = 1'h0;
		chk("idle", 1, idl);
		chk("source", `MTS_SRC_RESET, tsrc);
		chk("auto", 1, aon);
		chk("points", 0, pts);
		$display("reset done");
		t_store(3, 2, 6);
		t_store(600, 1, 512);
		t_discard();
		t_direct();
		t_ext();
		t_delay();
		t_free();
		results();
	end
endmodule // tb_measurement_trigger_sequencer
